// ---- common/dtp_params.svh ----
// Constants of the digital input telegram packer: offsets, fields, timing
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH

`define DTP_CLK_MHZ        200
`define DTP_REFRESH_US     6500
`define DTP_REFRESH_CYC    (`DTP_REFRESH_US * `DTP_CLK_MHZ)
`define DTP_MAX_IN_HZ      50
`define DTP_HALF_PERIOD_US (1000000 / (2 * `DTP_MAX_IN_HZ))

`define DTP_NCH            15
`define DTP_ADDR_W         8
`define DTP_DATA_W         32
`define DTP_TLG_BYTES      8
`define DTP_TLG_AW         3
`define DTP_LEN_W          4

`define DTP_OFF_CTRL       8'h00
`define DTP_OFF_SIM_MODE   8'h04
`define DTP_OFF_SIM_VAL    8'h08
`define DTP_OFF_SIM_QUAL   8'h0c
`define DTP_OFF_INVERT     8'h10
`define DTP_OFF_ERR_MODE   8'h14
`define DTP_OFF_SUBST      8'h18
`define DTP_OFF_SNAPSHOT   8'h1c
`define DTP_OFF_IRQ_STAT   8'h20
`define DTP_OFF_IRQ_MASK   8'h24

`define DTP_CTRL_ACTIVE    0
`define DTP_CTRL_CODE_LSB  1
`define DTP_CTRL_RST       3'h1
`define DTP_CH_RST         15'h0000
`define DTP_SIM_QUAL_RST   15'h7fff
`define DTP_ERR_MODE_RST   30'h00000000

`define DTP_IRQ_W          3
`define DTP_IRQ_REFRESH    0
`define DTP_IRQ_ERROR      1
`define DTP_IRQ_MISMATCH   2

`define DTP_LEN_IN_STD     4'h2
`define DTP_LEN_IN_QUAD    4'h4
`define DTP_LEN_IN_OCTAL   4'h8
`define DTP_LEN_OUT_STD    4'h0
`define DTP_LEN_OUT_DUAL   4'h2
`define DTP_LEN_OUT_QUAD   4'h4
`define DTP_LEN_OUT_OCTAL  4'h8

`endif

// ---- common/dtp_pkg.sv ----
// Types of the digital input telegram packer
package dtp_pkg;
   typedef enum logic [1:0] {
      dtp_code_standard,
      dtp_code_dual_in_dual_out_universal_entry,
      dtp_code_quad_in_quad_out_universal_entry,
      dtp_code_octal_in_octal_out_universal_entry
   } dtp_cfg_code_t;

   typedef enum logic [1:0] {
      dtp_err_current,
      dtp_err_substitute,
      dtp_err_last_valid,
      dtp_err_spare
   } dtp_err_mode_t;

   typedef enum logic {
      dtp_snap_idle,
      dtp_snap_store
   } dtp_snap_state_t;
endpackage

// ---- common/dtp_mem_if.sv ----
// Carrier between the packer core and its telegram memory
`timescale 1ns/10ps
`include "dtp_params.svh"
interface dtp_mem_if;
   logic                    wr_en;
   logic [1:0]              wr_word;
   logic [15:0]             wr_data;
   logic                    rd_en;
   logic [`DTP_TLG_AW-1:0]  rd_addr;
   logic [7:0]              rd_data;

   modport core (output wr_en, wr_word, wr_data, rd_en, rd_addr,
                 input rd_data);
   modport mem  (input wr_en, wr_word, wr_data, rd_en, rd_addr,
                 output rd_data);
endinterface

// ---- logic/dtp_refresh_timer.sv ----
// Free-running refresh period timer issuing one tick per period
`timescale 1ns/10ps
module dtp_refresh_timer #(
   parameter int REFRESH_CYC = 1300000
) (
   input  wire logic ref_clk,   // System clock
   input  wire logic rst_n,     // Asynchronous reset
   input  wire logic clk_en,    // Freezes the count while low
   output logic      tick       // One cycle per refresh period
);
   logic [20:0] cnt_reg;

   assign tick = clk_en && (cnt_reg == 21'(REFRESH_CYC - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 21'h000000;
      end else if (clk_en) begin
         if (tick) begin
            cnt_reg <= 21'h000000;
         end else begin
            cnt_reg <= cnt_reg + 21'h000001;
         end
      end
   end
endmodule

// ---- logic/dtp_tlg_mem.sv ----
// Telegram input byte store with a registered read port
`timescale 1ns/10ps
`include "dtp_params.svh"
module dtp_tlg_mem (
   input  wire logic ref_clk,   // System clock
   input  wire logic rst_n,     // Asynchronous reset
   input  wire logic clk_en,    // Freezes state while low
   dtp_mem_if.mem    mif        // Word write, byte read
);
   logic [7:0] mem_reg [0:`DTP_TLG_BYTES-1];
   logic [7:0] rd_data_reg;

   assign mif.rd_data = rd_data_reg;

   // Bytes never written stay zero: they are the empty padding bytes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `DTP_TLG_BYTES; i++) begin
            mem_reg[i] <= 8'h00;
         end
      end else if (clk_en && mif.wr_en) begin
         mem_reg[{mif.wr_word, 1'b0}] <= mif.wr_data[15:8];
         mem_reg[{mif.wr_word, 1'b1}] <= mif.wr_data[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= 8'h00;
      end else if (clk_en && mif.rd_en) begin
         rd_data_reg <= mem_reg[mif.rd_addr];
      end
   end
endmodule

// ---- logic/dtp_packer.sv ----
// Fifteen-channel binary input telegram packer, top level
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "dtp_params.svh"
// Summary of operation
// - A new telegram is produced every refresh period while the codes match, regardless of bus polling.
// - Field inputs are sampled every clock, far faster than the 50 Hz limit.
// - Byte one holds channels nine to fifteen and the error flag, byte two channels one to eight.
// - Empty output bytes number zero, two, four or eight after the configuration code.
// - Input bytes three and four exist empty from code quad on, five to eight only for octal.
// - Cyclic data is exchanged only while master and station codes match exactly.
// - There is no line fault monitoring, so no line fault is ever reported.
// - In normal mode each channel reports its live field value.
// - In simulation mode a channel reports its configured simulated value.
// - Channel activity follows the single module-wide active bit.
// - The simulated value is one bit with a valid or invalid quality flag.
// - Inversion reports the complement of the field level.
// - On a fault a channel reports live, substitute or last valid value by its mode.
// - A substitute value always carries invalid quality.
module dtp_packer #(
   parameter int REFRESH_CYC = `DTP_REFRESH_CYC
) (
   input  wire logic                   ref_clk,        // 200 MHz clock
   input  wire logic                   rst_n,          // Async reset
   input  wire logic                   clk_en,         // Freezes all state
   input  wire logic [`DTP_NCH-1:0]    field_in,       // Field levels
   input  wire logic [`DTP_NCH-1:0]    chan_fault,     // Channel fault
   input  wire logic [1:0]             master_code,    // Master's code
   input  wire logic [`DTP_ADDR_W-1:0] reg_addr,       // Register address
   input  wire logic [`DTP_DATA_W-1:0] reg_wdata,      // Write data
   input  wire logic                   reg_wr,         // Write strobe
   input  wire logic                   reg_rd,         // Read strobe
   output logic      [`DTP_DATA_W-1:0] reg_rdata,      // Read data
   input  wire logic                   tlg_rd,         // Telegram byte read
   input  wire logic [`DTP_TLG_AW-1:0] tlg_addr,       // Byte index
   output logic      [7:0]             tlg_data,       // Byte, next cycle
   output logic      [`DTP_LEN_W-1:0]  tlg_in_len,     // Input bytes
   output logic      [`DTP_LEN_W-1:0]  tlg_out_len,    // Empty out bytes
   output logic                        tlg_exchange,   // Codes agree
   output logic                        tlg_update,     // New telegram
   output logic                        irq             // Interrupt level
);
   localparam int NCH = `DTP_NCH;

   dtp_mem_if mif ();

   logic                    refresh_tick;
   logic [NCH-1:0]          field_reg;
   logic [2:0]              ctrl_reg;
   logic [NCH-1:0]          sim_mode_reg;
   logic [NCH-1:0]          sim_val_reg;
   logic [NCH-1:0]          sim_qual_reg;
   logic [NCH-1:0]          invert_reg;
   logic [2*NCH-1:0]        err_mode_reg;
   logic [NCH-1:0]          subst_reg;
   logic [NCH-1:0]          last_valid_reg;
   logic [15:0]             snap_reg;
   logic [`DTP_IRQ_W-1:0]   irq_stat_reg;
   logic [`DTP_IRQ_W-1:0]   irq_stat_next;
   logic [`DTP_IRQ_W-1:0]   irq_mask_reg;
   logic [`DTP_IRQ_W-1:0]   irq_event;
   logic [`DTP_DATA_W-1:0]  rdata_reg;
   logic [`DTP_DATA_W-1:0]  rdata_next;
   logic                    tlg_update_reg;
   logic                    err_prev_reg;
   logic [NCH-1:0]          chan_val;
   logic [NCH-1:0]          chan_qual;
   logic                    module_active;
   logic                    code_match;
   logic                    collective_err;
   dtp_pkg::dtp_cfg_code_t  cfg_code;
   dtp_pkg::dtp_snap_state_t snap_state;
   dtp_pkg::dtp_snap_state_t snap_state_next;

   assign module_active  = ctrl_reg[`DTP_CTRL_ACTIVE];
   assign cfg_code       = dtp_pkg::dtp_cfg_code_t'(ctrl_reg[2:1]);
   assign code_match     = (master_code == ctrl_reg[2:1]);
   assign collective_err = ~&chan_qual;
   assign tlg_exchange   = code_match;
   assign tlg_update     = tlg_update_reg;
   assign reg_rdata      = rdata_reg;
   assign tlg_data       = mif.rd_data;
   assign irq            = |(irq_stat_reg & irq_mask_reg);

   dtp_refresh_timer #(
      .REFRESH_CYC (REFRESH_CYC)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .tick    (refresh_tick)
   );

   dtp_tlg_mem u_mem (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .mif     (mif.mem)
   );

   // Field capture every clock; the refresh period is below half a 50 Hz cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         field_reg <= `DTP_CH_RST;
      end else if (clk_en) begin
         field_reg <= field_in;
      end
   end

   // Lengths of the telegram follow the configuration code
   always_comb begin
      tlg_in_len  = `DTP_LEN_IN_STD;
      tlg_out_len = `DTP_LEN_OUT_STD;
      case (cfg_code)
         dtp_pkg::dtp_code_dual_in_dual_out_universal_entry: begin
            tlg_out_len = `DTP_LEN_OUT_DUAL;
         end
         dtp_pkg::dtp_code_quad_in_quad_out_universal_entry: begin
            tlg_in_len  = `DTP_LEN_IN_QUAD;
            tlg_out_len = `DTP_LEN_OUT_QUAD;
         end
         dtp_pkg::dtp_code_octal_in_octal_out_universal_entry: begin
            tlg_in_len  = `DTP_LEN_IN_OCTAL;
            tlg_out_len = `DTP_LEN_OUT_OCTAL;
         end
         default: begin
            tlg_in_len  = `DTP_LEN_IN_STD;
            tlg_out_len = `DTP_LEN_OUT_STD;
         end
      endcase
   end

   // Per-channel value and quality; fault input is the channel's own fault,
   // never a line monitor
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_chan
         logic                  live;
         dtp_pkg::dtp_err_mode_t emode;

         assign live  = field_reg[ch] ^ invert_reg[ch];
         assign emode = dtp_pkg::dtp_err_mode_t'(err_mode_reg[2*ch +: 2]);

         always_comb begin
            chan_val[ch]  = live;
            chan_qual[ch] = 1'b1;
            if (!module_active) begin
               chan_val[ch]  = 1'b0;
               chan_qual[ch] = 1'b1;
            end else if (sim_mode_reg[ch]) begin
               chan_val[ch]  = sim_val_reg[ch];
               chan_qual[ch] = sim_qual_reg[ch];
            end else if (chan_fault[ch]) begin
               chan_qual[ch] = 1'b0;
               case (emode)
                  dtp_pkg::dtp_err_substitute: begin
                     chan_val[ch] = subst_reg[ch];
                  end
                  dtp_pkg::dtp_err_last_valid: begin
                     chan_val[ch] = last_valid_reg[ch];
                  end
                  default: begin
                     chan_val[ch] = live;
                  end
               endcase
            end else begin
               chan_val[ch] = live;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               last_valid_reg[ch] <= 1'b0;
            end else if (clk_en && module_active && !sim_mode_reg[ch]
                         && !chan_fault[ch]) begin
               last_valid_reg[ch] <= live;
            end
         end
      end
   endgenerate

   // Snapshot of both input bytes taken in one cycle per period
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_reg <= 16'h0000;
      end else if (clk_en && refresh_tick && code_match) begin
         snap_reg <= {collective_err, chan_val[14:8], chan_val[7:0]};
      end
   end

   always_comb begin
      snap_state_next = snap_state;
      case (snap_state)
         dtp_pkg::dtp_snap_idle: begin
            if (refresh_tick && code_match) begin
               snap_state_next = dtp_pkg::dtp_snap_store;
            end
         end
         dtp_pkg::dtp_snap_store: begin
            snap_state_next = dtp_pkg::dtp_snap_idle;
         end
         default: begin
            snap_state_next = dtp_pkg::dtp_snap_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_state <= dtp_pkg::dtp_snap_idle;
      end else if (clk_en) begin
         snap_state <= snap_state_next;
      end
   end

   // Whole snapshot goes to the store as one word
   assign mif.wr_en   = (snap_state == dtp_pkg::dtp_snap_store);
   assign mif.wr_word = 2'h0;
   assign mif.wr_data = snap_reg;
   assign mif.rd_en   = tlg_rd && code_match;
   assign mif.rd_addr = tlg_addr;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tlg_update_reg <= 1'b0;
      end else if (clk_en) begin
         tlg_update_reg <= mif.wr_en;
      end
   end

   // Register writes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= `DTP_CTRL_RST;
         sim_mode_reg <= `DTP_CH_RST;
         sim_val_reg  <= `DTP_CH_RST;
         sim_qual_reg <= `DTP_SIM_QUAL_RST;
         invert_reg   <= `DTP_CH_RST;
         err_mode_reg <= `DTP_ERR_MODE_RST;
         subst_reg    <= `DTP_CH_RST;
         irq_mask_reg <= 3'h0;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `DTP_OFF_CTRL) begin
            ctrl_reg <= reg_wdata[2:0];
         end else if (reg_addr == `DTP_OFF_SIM_MODE) begin
            sim_mode_reg <= reg_wdata[NCH-1:0];
         end else if (reg_addr == `DTP_OFF_SIM_VAL) begin
            sim_val_reg <= reg_wdata[NCH-1:0];
         end else if (reg_addr == `DTP_OFF_SIM_QUAL) begin
            sim_qual_reg <= reg_wdata[NCH-1:0];
         end else if (reg_addr == `DTP_OFF_INVERT) begin
            invert_reg <= reg_wdata[NCH-1:0];
         end else if (reg_addr == `DTP_OFF_ERR_MODE) begin
            err_mode_reg <= reg_wdata[2*NCH-1:0];
         end else if (reg_addr == `DTP_OFF_SUBST) begin
            subst_reg <= reg_wdata[NCH-1:0];
         end else if (reg_addr == `DTP_OFF_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[`DTP_IRQ_W-1:0];
         end
      end
   end

   // Register reads, answered in the following cycle
   always_comb begin
      rdata_next = 32'h00000000;
      if (reg_addr == `DTP_OFF_CTRL) begin
         rdata_next[2:0] = ctrl_reg;
      end else if (reg_addr == `DTP_OFF_SIM_MODE) begin
         rdata_next[NCH-1:0] = sim_mode_reg;
      end else if (reg_addr == `DTP_OFF_SIM_VAL) begin
         rdata_next[NCH-1:0] = sim_val_reg;
      end else if (reg_addr == `DTP_OFF_SIM_QUAL) begin
         rdata_next[NCH-1:0] = sim_qual_reg;
      end else if (reg_addr == `DTP_OFF_INVERT) begin
         rdata_next[NCH-1:0] = invert_reg;
      end else if (reg_addr == `DTP_OFF_ERR_MODE) begin
         rdata_next[2*NCH-1:0] = err_mode_reg;
      end else if (reg_addr == `DTP_OFF_SUBST) begin
         rdata_next[NCH-1:0] = subst_reg;
      end else if (reg_addr == `DTP_OFF_SNAPSHOT) begin
         rdata_next[15:0] = snap_reg;
         rdata_next[16]   = code_match;
      end else if (reg_addr == `DTP_OFF_IRQ_STAT) begin
         rdata_next[`DTP_IRQ_W-1:0] = irq_stat_reg;
      end else if (reg_addr == `DTP_OFF_IRQ_MASK) begin
         rdata_next[`DTP_IRQ_W-1:0] = irq_mask_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h00000000;
      end else if (clk_en) begin
         rdata_reg <= reg_rd ? rdata_next : 32'h00000000;
      end
   end

   // Sticky events; a new event wins over a write-one clear
   always_comb begin
      irq_event = 3'h0;
      irq_event[`DTP_IRQ_REFRESH]  = tlg_update_reg;
      irq_event[`DTP_IRQ_ERROR]    = collective_err && !err_prev_reg;
      irq_event[`DTP_IRQ_MISMATCH] = refresh_tick && !code_match;
      irq_stat_next = irq_stat_reg;
      if (reg_wr && reg_addr == `DTP_OFF_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~reg_wdata[`DTP_IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_event;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= 3'h0;
         err_prev_reg <= 1'b0;
      end else if (clk_en) begin
         irq_stat_reg <= irq_stat_next;
         err_prev_reg <= collective_err;
      end
   end

   // Checking helpers: enabled cycles since the last refresh tick
   logic [20:0] gap_cnt_reg;
   logic        seen_tick_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_cnt_reg   <= 21'h000000;
         seen_tick_reg <= 1'b0;
      end else if (clk_en) begin
         gap_cnt_reg   <= refresh_tick ? 21'h000000 : gap_cnt_reg + 21'h000001;
         seen_tick_reg <= seen_tick_reg | refresh_tick;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_take;
      clk_en && refresh_tick && code_match;
   endsequence

   sequence s_store;
      mif.wr_en ##1 tlg_update;
   endsequence

   a_refresh_gap: assert property (
      refresh_tick && seen_tick_reg |->
         gap_cnt_reg == 21'(REFRESH_CYC - 1))
      else $error("refresh period wrong");

   a_byte_layout: assert property (
      s_take |=> snap_reg == {$past(collective_err), $past(chan_val)})
      else $error("snapshot byte layout wrong");

   a_snap_store: assert property (
      s_take ##1 clk_en |-> s_store)
      else $error("snapshot not stored as one word");

   a_out_len: assert property (
      tlg_out_len == (ctrl_reg[2:1] == 2'h0 ? 4'h0 :
                      ctrl_reg[2:1] == 2'h1 ? 4'h2 :
                      ctrl_reg[2:1] == 2'h2 ? 4'h4 : 4'h8))
      else $error("output padding length wrong");

   a_in_len: assert property (
      tlg_in_len == (ctrl_reg[2] ? (ctrl_reg[1] ? 4'h8 : 4'h4) : 4'h2))
      else $error("input length wrong");

   a_empty_bytes: assert property (
      clk_en && mif.rd_en && tlg_addr >= 3'h2 |=> tlg_data == 8'h00)
      else $error("padding byte not empty");

   a_code_gate: assert property (
      clk_en && refresh_tick && !code_match |=> $stable(snap_reg))
      else $error("telegram changed with mismatched code");

   a_normal_live: assert property (
      module_active && !sim_mode_reg[0] && !chan_fault[0] |->
         chan_val[0] == (field_reg[0] ^ invert_reg[0]) && chan_qual[0])
      else $error("normal channel not live");

   a_sim_value: assert property (
      module_active && sim_mode_reg[1] |->
         chan_val[1] == sim_val_reg[1] && chan_qual[1] == sim_qual_reg[1])
      else $error("simulated value not reported");

   a_inactive: assert property (
      !module_active |-> chan_val == 15'h0000 && !collective_err)
      else $error("inactive module reports data");

   a_substitute: assert property (
      module_active && !sim_mode_reg[0] && chan_fault[0] &&
      err_mode_reg[1:0] == 2'h1 |->
         chan_val[0] == subst_reg[0] && !chan_qual[0])
      else $error("substitute value or quality wrong");

   a_last_valid: assert property (
      clk_en && module_active && !sim_mode_reg[1] && !chan_fault[1]
      ##1 chan_fault[1] && err_mode_reg[3:2] == 2'h2 && module_active
      && !sim_mode_reg[1] |->
         chan_val[1] == $past(field_reg[1] ^ invert_reg[1]))
      else $error("last valid value lost");

   a_no_line_fault: assert property (
      chan_fault == 15'h0000 && (~sim_mode_reg | sim_qual_reg) == 15'h7fff
      |-> !collective_err)
      else $error("error flag without a fault");
endmodule

// ---- bench/dtp_comm_model.sv ----
// Communication unit model fetching both input bytes and one padding byte
`timescale 1ns/10ps
module dtp_comm_model (
   input  wire logic        ref_clk,    // System clock
   input  wire logic        rst_n,      // Async reset
   input  wire logic        tlg_update, // New telegram
   input  wire logic [7:0]  tlg_data,   // Byte read
   output logic             tlg_rd,     // Byte read strobe
   output logic [2:0]       tlg_addr,   // Byte index
   output logic [15:0]      tlg_word,   // Input bytes one and two
   output int               n_got       // Telegrams fetched
);
   logic [1:0] step_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_reg <= 2'h0;
         tlg_rd <= 1'b0;
         tlg_addr <= 3'h0;
         tlg_word <= 16'h0000;
         n_got <= 0;
      end else begin
         case (step_reg)
            2'h0: begin
               tlg_addr <= tlg_update ? 3'h0 : ~tlg_addr;
               tlg_rd <= tlg_update;
               step_reg <= tlg_update ? 2'h1 : 2'h0;
            end
            2'h1: begin
               tlg_addr <= 3'h1;
               step_reg <= 2'h2;
            end
            2'h2: begin
               tlg_addr <= 3'h6;
               tlg_word[15:8] <= tlg_data;
               step_reg <= 2'h3;
            end
            default: begin
               tlg_rd <= 1'b0;
               tlg_word[7:0] <= tlg_data;
               n_got <= n_got + 1;
               step_reg <= 2'h0;
            end
         endcase
      end
   end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the telegram packer
`timescale 1ns/10ps
`include "dtp_params.svh"
module tb_top;
   logic ref_clk, rst_n, reg_wr, reg_rd, tlg_rd, tlg_update, irq, tlg_exchange;
   logic [14:0] field_in, chan_fault;
   logic [1:0]  master_code;
   logic        clk_en;
   logic [7:0]  reg_addr, tlg_data;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0]  tlg_addr;
   logic [3:0]  tlg_in_len, tlg_out_len;
   logic [15:0] tlg_word;
   int n_got, n_fail, tests_run, k, base;
   typedef struct {logic [14:0] fld, inv, sm, sv; logic [15:0] exp;} dtp_row_t;
   dtp_row_t rows[4] = '{'{15'h0001, 15'h0000, 15'h0000, 15'h0000, 16'h0001},
                     '{15'h4100, 15'h0000, 15'h0000, 15'h0000, 16'h4100},
                     '{15'h00ff, 15'h7fff, 15'h0000, 15'h0000, 16'h7f00},
                     '{15'h7fff, 15'h0000, 15'h000f, 15'h0005, 16'h7ff5}};
   logic [3:0] in_t[4] = '{4'h2, 4'h2, 4'h4, 4'h8};
   logic [3:0] out_t[4] = '{4'h0, 4'h2, 4'h4, 4'h8};
   dtp_packer #(.REFRESH_CYC(50)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .clk_en(clk_en), .field_in(field_in), .chan_fault(chan_fault),
      .master_code(master_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tlg_rd(tlg_rd), .tlg_addr(tlg_addr), .tlg_data(tlg_data),
      .tlg_in_len(tlg_in_len), .tlg_out_len(tlg_out_len),
      .tlg_exchange(tlg_exchange), .tlg_update(tlg_update), .irq(irq));
   dtp_comm_model comm_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .tlg_update(tlg_update), .tlg_data(tlg_data), .tlg_rd(tlg_rd),
      .tlg_addr(tlg_addr), .tlg_word(tlg_word), .n_got(n_got));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata & m);
   endtask
   // Two fetches so the second telegram follows every setting change
   task automatic wait_tlg();
      base = n_got;
      for (k = 0; k < 400 && n_got < base + 2; k++) @(posedge ref_clk);
      #1;
      chk("fetches", 32'h1, n_got >= base + 2);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      close_out();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, master_code} = '0;
      {field_in, chan_fault} = '0;
      clk_en = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`DTP_OFF_CTRL, 32'hffffffff, 32'h1);
      rd(`DTP_OFF_SIM_QUAL, 32'hffffffff, 32'h7fff);
      rd(8'h3c, 32'hffffffff, 32'h0);
      foreach (rows[i]) begin
         field_in <= rows[i].fld;
         wr(`DTP_OFF_INVERT, {17'h0, rows[i].inv});
         wr(`DTP_OFF_SIM_MODE, {17'h0, rows[i].sm});
         wr(`DTP_OFF_SIM_VAL, {17'h0, rows[i].sv});
         wait_tlg();
         chk("telegram", rows[i].exp, tlg_word);
         chk("pad byte", 32'h0, tlg_data);
      end
      wr(`DTP_OFF_SIM_MODE, 32'h0);
      wr(`DTP_OFF_INVERT, 32'h0);
      wr(`DTP_OFF_ERR_MODE, 32'h9);
      wr(`DTP_OFF_SUBST, 32'h1);
      field_in <= 15'h0006;
      wait_tlg();
      @(posedge ref_clk);
      field_in <= 15'h0000;
      chan_fault <= 15'h0007;
      wait_tlg();
      chk("fault telegram", 32'h8003, tlg_word);
      chk("irq masked", 32'h0, irq);
      wr(`DTP_OFF_IRQ_MASK, 32'h2);
      chk("irq raised", 32'h1, irq);
      wr(`DTP_OFF_IRQ_STAT, 32'h2);
      chk("irq cleared", 32'h0, irq);
      chan_fault <= 15'h0000;
      @(posedge tlg_update);
      @(posedge ref_clk) #1;
      for (k = 1; k < 200 && tlg_update !== 1'b1; k++) @(posedge ref_clk) #1;
      chk("refresh period", 50, k);
      // Let the fetch of this telegram finish before the codes part
      repeat (5) @(posedge ref_clk);
      master_code <= 2'h1;
      #1 chk("exchange off", 32'h0, tlg_exchange);
      base = n_got;
      repeat (120) @(posedge ref_clk);
      chk("frozen", base, n_got);
      rd(`DTP_OFF_IRQ_STAT, 32'h4, 32'h4);
      for (int c = 0; c < 4; c++) begin
         master_code <= c[1:0];
         wr(`DTP_OFF_CTRL, {29'h0, c[1:0], 1'b1});
         chk("exchange", 32'h1, tlg_exchange);
         chk("in len", in_t[c], tlg_in_len);
         chk("out len", out_t[c], tlg_out_len);
      end
      wr(`DTP_OFF_CTRL, 32'h6);
      field_in <= 15'h7fff;
      wait_tlg();
      chk("inactive", 32'h0, tlg_word);
      clk_en <= 1'b0;
      base = n_got;
      repeat (120) @(posedge ref_clk);
      chk("frozen clock", base, n_got);
      clk_en <= 1'b1;
      wait_tlg();
      close_out();
   end
endmodule
